// >>> hw/phy_ctl_consts.vh
// Constants for the management, power-down and reset pin block
//
// Overview of operation
// [R01] Management clock at most 25 MHz, no minimum; the 20 MHz sampler here resolves only slower clocks
// [R02] Management clock unrelated to MAC clocks
// [R03] Shared data line driven by station or device
// [R04] Combined pin is power-down input after reset
// [R05] Pin low in input role enters power-down
// [R06] Registers stay reachable during power-down
// [R07] Interrupt role only pulls low or releases
// [R08] Reset pin returns all registers to defaults
// [R09] Reset pin held low at least 1 us
// [R10] Reset and power-down inputs are synchronised
`ifndef PHY_CTL_CONSTS_VH
`define PHY_CTL_CONSTS_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS      50
`define RST_MIN_NS         1000
// Least reset width in cycles, rounded up
`define RST_MIN_CYC        ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MDC_MAX_KHZ        25000

// ----------------------------------------------------------------------
// Management frame fields
// ----------------------------------------------------------------------
`define ST_CODE            2'h1
`define OP_WRITE           2'h1
`define OP_READ            2'h2
`define PRE_BITS           32
`define REG_CTL            5'h00
`define REG_STS            5'h01
`define REG_IRQ            5'h02
// Control register bits
`define CTL_RESET_BIT      15
`define CTL_PDOWN_BIT      11
`define CTL_IRQ_ROLE_BIT   0
`define CTL_RESET_VAL      16'h0000
`define IRQ_RESET_VAL      16'h0000

`endif

// >>> hw/mgmt_frame.v
// Serial management frame engine, sampled on the system clock
`include "phy_ctl_consts.vh"
module mgmt_frame
#(
    parameter PHY_ADDR = 5'h01          // Address this device answers to
)
(
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        ce,
    input  wire        mdc_rise,        // Management clock rising edge
    input  wire        mdc_fall,        // Management clock falling edge
    input  wire        mdio_s,          // Synchronised data line
    input  wire [15:0] rd_data,         // Data for read answer
    output reg         mdio_o,          // Drive value (always 0 or data)
    output reg         mdio_oe,         // High while device drives
    output reg         wr_stb,          // One-cycle register write
    output reg         rd_stb,          // One-cycle register read
    output reg  [4:0]  reg_addr,        // Register address
    output reg  [15:0] wr_data          // Register write data
);
    // ------------------------------------------------------------------
    // Frame shifter
    // ------------------------------------------------------------------
    reg [5:0]  ones_ff;                 // Preamble ones count
    reg [5:0]  cnt_ff;                  // Bit position after preamble
    reg        act_ff;                  // Inside a frame
    reg [13:0] hdr_ff;                  // ST, OP, PHYAD, REGAD
    reg [15:0] sh_ff;                   // Data shifter
    reg        rd_ff;                   // Read frame addressed to us
    reg        wr_ff;                   // Write frame addressed to us

    // Sample on rising edge, drive on falling edge  [R03]
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ones_ff  <= 6'h00;
            cnt_ff   <= 6'h00;
            act_ff   <= 1'b0;
            hdr_ff   <= 14'h0000;
            sh_ff    <= 16'h0000;
            rd_ff    <= 1'b0;
            wr_ff    <= 1'b0;
            mdio_o   <= 1'b0;
            mdio_oe  <= 1'b0;
            wr_stb   <= 1'b0;
            rd_stb   <= 1'b0;
            reg_addr <= 5'h00;
            wr_data  <= 16'h0000;
        end
        else if (ce)
        begin
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            if (mdc_rise)
            begin
                if (!act_ff)
                begin
                    // Start bit 0 after enough preamble ones
                    if (mdio_s)
                        ones_ff <= (ones_ff == 6'h3f) ? ones_ff : ones_ff + 6'h01;
                    else if (ones_ff >= 6'd32)
                    begin
                        act_ff  <= 1'b1;
                        cnt_ff  <= 6'h01;
                        hdr_ff  <= 14'h0000;
                        ones_ff <= 6'h00;
                    end
                    else
                        ones_ff <= 6'h00;
                end
                else
                begin
                    cnt_ff <= cnt_ff + 6'h01;
                    if (cnt_ff < 6'd14)
                        hdr_ff <= {hdr_ff[12:0], mdio_s};
                    if (cnt_ff == 6'd13)
                    begin
                        // Header complete: decide role
                        // Start 0 already taken; 12 bits held: ST 1, OP, PHYAD, REGAD[4:1]
                        reg_addr <= {hdr_ff[3:0], mdio_s};
                        rd_ff <= (hdr_ff[11] == 1'b1) && (hdr_ff[8:4] == PHY_ADDR)
                                 && (hdr_ff[10:9] == `OP_READ);
                        wr_ff <= (hdr_ff[11] == 1'b1) && (hdr_ff[8:4] == PHY_ADDR)
                                 && (hdr_ff[10:9] == `OP_WRITE);
                    end
                    // Data bits are taken in unless this is our read; read data shifts out on the fall
                    if (cnt_ff >= 6'd16 && !rd_ff)
                        sh_ff <= {sh_ff[14:0], mdio_s};
                    if (cnt_ff == 6'd31)
                    begin
                        act_ff <= 1'b0;
                        rd_ff  <= 1'b0;
                        if (wr_ff)
                        begin
                            wr_stb  <= 1'b1;
                            wr_data <= {sh_ff[14:0], mdio_s};
                        end
                        wr_ff <= 1'b0;
                    end
                end
            end
            if (mdc_fall)
            begin
                // Turnaround: release, then drive 0 then data MSB first  [R03]
                if (rd_ff && cnt_ff == 6'd15)
                begin
                    mdio_oe <= 1'b1;
                    mdio_o  <= 1'b0;
                    sh_ff   <= rd_data;
                    // Read side effects only after the value is captured
                    rd_stb  <= 1'b1;
                end
                else if (rd_ff && cnt_ff >= 6'd16 && cnt_ff <= 6'd31)
                begin
                    mdio_o <= sh_ff[15];
                    sh_ff  <= {sh_ff[14:0], 1'b0};
                end
                else
                begin
                    mdio_oe <= 1'b0;
                    mdio_o  <= 1'b0;
                end
            end
        end
    end
endmodule // mgmt_frame

// >>> hw/phy_mgmt_power_reset_pins.v
// Top of the management, power-down and reset pin logic
`include "phy_ctl_consts.vh"
module phy_mgmt_power_reset_pins
#(
    parameter PHY_ADDR = 5'h01              // Management address, arbitrary default
)
(
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        ce,
    input  wire        mdc,                 // Management clock pin
    input  wire        mdio_i,              // Data line level
    output wire        mdio_o,              // Data line drive value
    output wire        mdio_oe,             // Data line drive enable
    input  wire        reset_n_pin,         // Hardware reset pin, active low
    input  wire        irq_or_sleep_pin_i,  // Combined pin level
    output wire        irq_or_sleep_pin_o,  // Combined pin drive value
    output wire        irq_or_sleep_pin_oe, // Combined pin drive enable
    input  wire        irq_event,           // Internal event pulse
    output wire        power_down,          // Device is in power-down
    output wire        dev_reset            // Internal reset to the rest
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg [1:0] mdc_sy_ff;        // Management clock, two stages
    reg       mdc_d_ff;         // Previous synchronised clock
    reg [1:0] mdio_sy_ff;       // Data line, two stages
    reg [1:0] rst_sy_ff;        // Reset pin, two stages
    reg [1:0] pd_sy_ff;         // Combined pin, two stages

    // Management clock sampled, not used as a clock: unrelated to MAC clocks  [R02]
    // Limitation: the 20 MHz sampler resolves a slower management clock only  [R01]
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mdc_sy_ff  <= 2'h0;
            mdc_d_ff   <= 1'b0;
            mdio_sy_ff <= 2'h3;
            rst_sy_ff  <= 2'h3;
            pd_sy_ff   <= 2'h3;
        end
        else if (ce)
        begin
            mdc_sy_ff  <= {mdc_sy_ff[0], mdc};
            mdc_d_ff   <= mdc_sy_ff[1];
            mdio_sy_ff <= {mdio_sy_ff[0], mdio_i};
            rst_sy_ff  <= {rst_sy_ff[0], reset_n_pin};          // [R10]
            pd_sy_ff   <= {pd_sy_ff[0], irq_or_sleep_pin_i};    // [R10]
        end
    end

    wire mdc_rise = mdc_sy_ff[1] & ~mdc_d_ff;  // Edge on second stage only
    wire mdc_fall = ~mdc_sy_ff[1] & mdc_d_ff;

    // ------------------------------------------------------------------
    // Reset width filter
    // ------------------------------------------------------------------
    localparam RCW = 6;
    reg [RCW-1:0] rcnt_ff;      // Cycles the pin has been low
    reg           hwrst_ff;     // Qualified hardware reset

    // Pulses shorter than the least width are ignored  [R09]
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rcnt_ff  <= {RCW{1'b0}};
            hwrst_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (rst_sy_ff[1])
            begin
                rcnt_ff  <= {RCW{1'b0}};
                hwrst_ff <= 1'b0;
            end
            else if (rcnt_ff >= `RST_MIN_CYC - 1)
                hwrst_ff <= 1'b1;                               // [R09]
            else
                rcnt_ff <= rcnt_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [15:0] ctl_ff;         // Control: reset, power-down, pin role
    reg         irq_pend_ff;    // Sticky event flag
    wire        wr_stb;
    wire        rd_stb;
    wire [4:0]  reg_addr;
    wire [15:0] wr_data;
    reg  [15:0] rd_data;        // Read mux

    wire irq_role = ctl_ff[`CTL_IRQ_ROLE_BIT];
    wire soft_rst = wr_stb & (reg_addr == `REG_CTL) & wr_data[`CTL_RESET_BIT];

    // Defaults on hardware or soft reset  [R08]
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctl_ff      <= `CTL_RESET_VAL;  // Pin acts as power-down input  [R04]
            irq_pend_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (hwrst_ff || soft_rst)
            begin
                ctl_ff      <= `CTL_RESET_VAL;                  // [R08]
                irq_pend_ff <= 1'b0;
            end
            else
            begin
                // Writes accepted even in power-down  [R06]
                if (wr_stb && reg_addr == `REG_CTL)
                    ctl_ff <= wr_data;
                // Set wins over read-clear
                if (irq_event)
                    irq_pend_ff <= 1'b1;
                else if (rd_stb && reg_addr == `REG_IRQ)
                    irq_pend_ff <= 1'b0;
            end
        end
    end

    // Pin low in input role enters power-down  [R05]
    assign power_down = ctl_ff[`CTL_PDOWN_BIT] | (~irq_role & ~pd_sy_ff[1]);
    assign dev_reset  = hwrst_ff;

    // Read mux
    always @*
    begin
        case (reg_addr)
            `REG_CTL: rd_data = ctl_ff;
            `REG_STS: rd_data = {14'h0000, hwrst_ff, power_down};
            `REG_IRQ: rd_data = {15'h0000, irq_pend_ff};
            default:  rd_data = 16'h0000;
        endcase
    end

    // Open drain: drive value fixed low, enable only  [R07]
    assign irq_or_sleep_pin_o  = 1'b0;
    assign irq_or_sleep_pin_oe = irq_role & irq_pend_ff;        // [R07]

    // ------------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------------
    mgmt_frame #(.PHY_ADDR(PHY_ADDR)) u_frame
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .mdc_rise (mdc_rise),
        .mdc_fall (mdc_fall),
        .mdio_s   (mdio_sy_ff[1]),
        .rd_data  (rd_data),
        .mdio_o   (mdio_o),
        .mdio_oe  (mdio_oe),
        .wr_stb   (wr_stb),
        .rd_stb   (rd_stb),
        .reg_addr (reg_addr),
        .wr_data  (wr_data)
    );
endmodule // phy_mgmt_power_reset_pins

// >>> bench/pins_chk_asserts.sv
// Port assertions for the management, power-down and reset pin block
`include "phy_ctl_consts.vh"
module pins_chk
(
    input logic clk,
    input logic sys_rst,
    input logic mdc,
    input logic mdio_o,
    input logic mdio_oe,
    input logic reset_n_pin,
    input logic irq_or_sleep_pin_i,
    input logic irq_or_sleep_pin_o,
    input logic irq_or_sleep_pin_oe,
    input logic power_down,
    input logic dev_reset
);
    // Cycles the reset pin has stayed low; saturates so a long hold never wraps
    logic [7:0] low_cnt_ff;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst) low_cnt_ff <= 8'h00;
        else if (reset_n_pin) low_cnt_ff <= 8'h00;
        else if (low_cnt_ff != 8'hff) low_cnt_ff <= low_cnt_ff + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_od; irq_or_sleep_pin_oe |-> !irq_or_sleep_pin_o; endproperty
    property p_role; $fell(sys_rst) |-> !irq_or_sleep_pin_oe; endproperty
    property p_pd_in;
        (!irq_or_sleep_pin_i && !irq_or_sleep_pin_oe) [*4] |-> power_down;
    endproperty
    // Synchroniser delay: a fresh low level must not act by the next edge
    property p_pd_sync; $fell(irq_or_sleep_pin_i) && !power_down |=> !power_down; endproperty
    property p_rmin; $rose(dev_reset) |-> low_cnt_ff >= `RST_MIN_CYC; endproperty
    property p_rend; dev_reset && $rose(reset_n_pin) |-> ##[1:6] !dev_reset; endproperty
    property p_rdef;
        (dev_reset && irq_or_sleep_pin_i) [*3] |=> !power_down && !irq_or_sleep_pin_oe;
    endproperty
    property p_hold; mdio_oe && mdc |-> $stable(mdio_o); endproperty
    a_od: assert property (p_od) else $error("pin driven high");
    a_role: assert property (p_role) else $error("pin not input after reset");
    a_pd_in: assert property (p_pd_in) else $error("no power-down on low pin");
    a_pd_sync: assert property (p_pd_sync) else $error("pin acted unsynchronised");
    a_rmin: assert property (p_rmin) else $error("reset accepted too short");
    a_rend: assert property (p_rend) else $error("reset did not end");
    a_rdef: assert property (p_rdef) else $error("control not at default");
    a_hold: assert property (p_hold) else $error("data changed while clock high");
    c_pd: cover property ($rose(power_down));
    c_rst: cover property ($rose(dev_reset));
    c_rd: cover property ($rose(mdio_oe));
endmodule // pins_chk
bind phy_mgmt_power_reset_pins pins_chk u_chk (.clk, .sys_rst, .mdc, .mdio_o, .mdio_oe,
    .reset_n_pin, .irq_or_sleep_pin_i, .irq_or_sleep_pin_o, .irq_or_sleep_pin_oe,
    .power_down, .dev_reset);

// >>> bench/mgmt_station.sv
// Management station model: drives the clock and its share of the data line
module mgmt_station
(
    input  logic clk,
    input  logic mdio_line,
    input  logic dev_oe,
    output logic mdc,
    output logic sta_oe,
    output logic sta_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Clock stands low between frames; the line is left to its pull-up
    initial
    begin
        mdc = 1'b0;
        sta_oe = 1'b0;
        sta_o = 1'b1;
    end
    // 16 system clocks a bit: 1.25 MHz, slow enough for the sampler
    task automatic frame(input [1:0] op, input [4:0] phy, input [4:0] ra,
                         input [15:0] wd, output [15:0] rd, output seen);
        logic [63:0] f;
        f = {32'hFFFF_FFFF, 2'h1, op, phy, ra, 2'h2, wd};
        rd = 16'h0000;
        seen = 1'b0;
        for (int i = 63; i >= 0; i--)
        begin
            @(posedge clk);
            mdc <= 1'b0;
            sta_oe <= !(op == 2'h2 && i < 18);
            sta_o <= f[i];
            repeat (8) @(posedge clk);
            mdc <= 1'b1;
            if (i < 16) rd[i] = mdio_line;
            seen = seen | dev_oe;
            repeat (7) @(posedge clk);
        end
        @(posedge clk);
        mdc <= 1'b0;
        sta_oe <= 1'b0;
    endtask
endmodule // mgmt_station

// >>> bench/phy_mgmt_power_reset_pins_tb.sv
// Self-checking bench for the management, power-down and reset pins
module phy_mgmt_power_reset_pins_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        ce = 1'b1;
    logic        reset_n_pin = 1'b1;
    logic        irq_event = 1'b0;
    logic        sleep_pull = 1'b0;   // When set, bench pulls the combined pin low
    logic [15:0] rd;
    logic        seen;
    int          err_total = 0;
    int          samples_checked = 0;
    wire mdc, mdio_o, mdio_oe, irq_or_sleep_pin_o, irq_or_sleep_pin_oe;
    wire power_down, dev_reset, sta_oe, sta_o;
    // Both shared lines have pull-ups
    wire mdio_i = mdio_oe ? mdio_o : (sta_oe ? sta_o : 1'b1);
    wire irq_or_sleep_pin_i = !((irq_or_sleep_pin_oe && !irq_or_sleep_pin_o) || sleep_pull);
    always #25 clk = ~clk;
    phy_mgmt_power_reset_pins uut (.clk, .sys_rst, .ce, .mdc, .mdio_i, .mdio_o, .mdio_oe,
        .reset_n_pin, .irq_or_sleep_pin_i, .irq_or_sleep_pin_o, .irq_or_sleep_pin_oe,
        .irq_event, .power_down, .dev_reset);
    mgmt_station sta (.clk, .mdio_line(mdio_i), .dev_oe(mdio_oe), .mdc, .sta_oe, .sta_o);
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input [15:0] got, input [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bounded wait: 0 power_down, 1 dev_reset, 2 pin pull enable
    task automatic wait_for(input int sel, input logic v);
        logic s;
        for (int n = 0; n < 80; n++)
        begin
            @(negedge clk);
            s = (sel == 0) ? power_down : (sel == 1) ? dev_reset : irq_or_sleep_pin_oe;
            if (s === v)
            begin
                samples_checked++;
                return;
            end
        end
        err_total++;
        $display("ERROR t=%0t wait %h exp %h", $time, sel, v);
        print_verdict();
    endtask
    task automatic wr(input [4:0] ra, input [15:0] d);
        sta.frame(2'h1, 5'h01, ra, d, rd, seen);
    endtask
    task automatic rdreg(input [4:0] ra, input [15:0] exp);
        sta.frame(2'h2, 5'h01, ra, 16'h0000, rd, seen);
        chk(rd, exp);
    endtask
    task automatic t_pin_pd;
        @(posedge clk) sleep_pull <= 1'b1;
        wait_for(0, 1'b1);
        rdreg(5'h01, 16'h0001);
        @(posedge clk) sleep_pull <= 1'b0;
        wait_for(0, 1'b0);
    endtask
    task automatic t_hw_reset;
        wr(5'h00, 16'h0800);
        wait_for(0, 1'b1);
        rdreg(5'h00, 16'h0800);
        @(posedge clk) reset_n_pin <= 1'b0;
        repeat (10) @(posedge clk);
        reset_n_pin <= 1'b1;
        repeat (6) @(negedge clk);
        chk({dev_reset, power_down}, 16'h0001);
        @(posedge clk) reset_n_pin <= 1'b0;
        wait_for(1, 1'b1);
        @(posedge clk) reset_n_pin <= 1'b1;
        wait_for(1, 1'b0);
        chk(power_down, 16'h0000);
        rdreg(5'h00, 16'h0000);
    endtask
    task automatic t_irq;
        wr(5'h00, 16'h0001);
        @(posedge clk) irq_event <= 1'b1;
        @(posedge clk) irq_event <= 1'b0;
        wait_for(2, 1'b1);
        repeat (8) @(negedge clk);
        chk({irq_or_sleep_pin_i, irq_or_sleep_pin_o, power_down}, 16'h0000);
        sta.frame(2'h2, 5'h01, 5'h02, 16'h0000, rd, seen);
        chk(rd, 16'h0001);
        wait_for(2, 1'b0);
        wr(5'h00, 16'h0000);
        // Soft reset bit: control returns to default, write not kept
        wr(5'h00, 16'h8800);
        rdreg(5'h00, 16'h0000);
    endtask
    // Frame for another address: line must stay with its pull-up
    task automatic t_refuse;
        sta.frame(2'h2, 5'h02, 5'h01, 16'h0000, rd, seen);
        chk({15'h0000, seen}, 16'h0000);
        chk(rd, 16'hffff);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk({mdio_oe, irq_or_sleep_pin_oe, power_down, dev_reset}, 16'h0000);
        t_pin_pd();
        t_hw_reset();
        t_irq();
        t_refuse();
        print_verdict();
    end
endmodule // phy_mgmt_power_reset_pins_tb
